/* core/rlme_pkg.sv */
/*
 * Shared constants and types of the left-rotate execution unit.
 * Assumes a byte-wide external memory with fixed-latency reads.
 */
package rlme_pkg;
	localparam logic [7:0] RLME_PFX_FIRST  = 8'hdd;
	localparam logic [7:0] RLME_PFX_SECOND = 8'hfd;
	localparam logic [7:0] RLME_PFX_BITOP  = 8'hcb;
	localparam logic [7:0] RLME_OP_RLC_MEM = 8'h06;
	localparam logic [7:0] RLME_OP_RL_MEM  = 8'h16;
	localparam logic [2:0] RLME_SEL_MEM    = 3'h6;
	localparam int         RLME_THRU_BIT   = 4;
	// Flag byte layout
	localparam int RLME_FLAG_S  = 7;
	localparam int RLME_FLAG_Z  = 6;
	localparam int RLME_FLAG_H  = 4;
	localparam int RLME_FLAG_PV = 2;
	localparam int RLME_FLAG_N  = 1;
	localparam int RLME_FLAG_C  = 0;
	// Register file index
	localparam logic [2:0] RLME_IDX_H = 3'h4;
	localparam logic [2:0] RLME_IDX_L = 3'h5;
	localparam logic [2:0] RLME_IDX_A = 3'h7;
	// Clock states per machine cycle
	localparam logic [2:0] RLME_T_FETCH    = 3'h4;
	localparam logic [2:0] RLME_T_DISP     = 3'h3;
	localparam logic [2:0] RLME_T_XFETCH   = 3'h5;
	localparam logic [2:0] RLME_T_IDX_READ = 3'h4;
	localparam logic [2:0] RLME_T_PTR_READ = 3'h4;
	localparam logic [2:0] RLME_T_WRITE    = 3'h3;
	localparam logic [15:0] RLME_PC_RESET  = 16'h0000;

	typedef enum logic [2:0] {
		PH_FETCH_FIRST,
		PH_FETCH_SECOND,
		PH_READ_DISP,
		PH_FETCH_XOP,
		PH_MEM_READ,
		PH_MEM_WRITE
	} rlme_phase_t;

	typedef struct packed {
		logic [15:0] addr;
		logic        rd;
		logic        wr;
		logic [7:0]  wdata;
	} rlme_bus_t;

	typedef struct packed {
		logic        load;
		logic [15:0] pc;
		logic [15:0] pointer_pair;
		logic [15:0] index_reg_first;
		logic [15:0] index_reg_second;
		logic [7:0]  acc;
		logic [7:0]  flags;
	} rlme_preset_t;

	typedef struct packed {
		logic        done;
		logic        busy;
		logic [7:0]  acc;
		logic [7:0]  flags;
		logic [15:0] pointer_pair;
		logic [15:0] pc;
	} rlme_status_t;
endpackage

/* core/rlme_rotate_unit.sv */
/*
 * Combinational left-rotate with flag generation.
 * Assumes the caller registers result and flags.
 */
`timescale 1ns/1ps
module rlme_rotate_unit (
	input  wire logic [7:0] operand,
	input  wire logic       thru_carry,
	input  wire logic [7:0] flags_in,
	output logic      [7:0] result,
	output logic      [7:0] flags_out
);
	import rlme_pkg::*;

	always_comb begin
		if (thru_carry) begin
			result = {operand[6:0], flags_in[RLME_FLAG_C]}; // RULE13
		end else begin
			result = {operand[6:0], operand[7]}; // RULE1
		end
		// Undefined flag bits keep their old value
		flags_out = flags_in;
		flags_out[RLME_FLAG_C]  = operand[7]; // RULE1
		flags_out[RLME_FLAG_S]  = result[7]; // RULE8
		flags_out[RLME_FLAG_Z]  = (result == 8'h00); // RULE9
		flags_out[RLME_FLAG_PV] = ~^result; // RULE10
		flags_out[RLME_FLAG_H]  = 1'b0; // RULE10
		flags_out[RLME_FLAG_N]  = 1'b0; // RULE10
	end
endmodule

/* core/rlme_exec.sv */
/*
 * Fetch, decode and execution of the bit-operation left rotates.
 * Assumes memory returns read data by the last clock state of a read cycle.
 */
// Overview of operation
// RULE1: Circular rotate shifts left, old bit 7 goes to bit 0 and carry.
// RULE2: First indexed form addresses first index register plus signed displacement.
// RULE3: Second indexed form addresses second index register plus signed displacement.
// RULE4: Indexed rotate takes six machine cycles, 23 states: 4,4,3,5,4,3.
// RULE5: First indexed form opens with prefix DD, then bit prefix, displacement, opcode.
// RULE6: Second indexed form opens with prefix FD, otherwise identical.
// RULE7: Indexed forms: third byte displacement, fourth opcode; 06 is circular rotate.
// RULE8: Sign flag follows result bit 7.
// RULE9: Zero flag set when the result is zero.
// RULE10: Parity flag set on even parity; half-carry and subtract cleared.
// RULE11: Rotate through carry accepts register, pointer pair and both indexed forms.
// RULE12: Bit prefix followed by 16 selects rotate through carry on pointer memory.
// RULE13: Through-carry rotate: old bit 7 to carry, old carry to bit 0.
// RULE14: Low three opcode bits pick B,C,D,E,H,L for 000-101, accumulator for 111.
// RULE15: Memory forms read the byte, rotate it, write it back to the same address.
`timescale 1ns/1ps
module rlme_exec #(
	parameter int TSTATE_DIV = 1
) (
	input  wire logic                  sys_clk,
	input  wire logic                  reset,
	input  wire rlme_pkg::rlme_preset_t preset,
	input  wire logic [7:0]            mem_rdata,
	output rlme_pkg::rlme_bus_t        mem_bus,
	output rlme_pkg::rlme_status_t     status
);
	import rlme_pkg::*;

	typedef struct packed {
		logic [7:0]      div_cnt;
		rlme_phase_t     phase;
		logic [2:0]      tcnt;
		logic            indexed;
		logic            second;
		logic [15:0]     pc;
		logic [15:0]     ix;
		logic [15:0]     iy;
		logic [7:0][7:0] gpr;
		logic [7:0]      flags;
		logic [7:0]      disp;
		logic [7:0]      opcode;
		logic [15:0]     ea;
		logic            done;
		rlme_bus_t       bus;
	} rlme_exec_state_t;

	rlme_exec_state_t s_reg;
	rlme_exec_state_t s_next;
	logic             tick;
	logic             last_t;
	logic [7:0]       rot_in;
	logic             rot_thru;
	logic [7:0]       rot_result;
	logic [7:0]       rot_flags;

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [2:0] mcycle_len(input rlme_phase_t ph, input logic idx);
		case (ph)
			PH_FETCH_FIRST:  mcycle_len = RLME_T_FETCH;
			PH_FETCH_SECOND: mcycle_len = RLME_T_FETCH;
			PH_READ_DISP:    mcycle_len = RLME_T_DISP;
			PH_FETCH_XOP:    mcycle_len = RLME_T_XFETCH;
			PH_MEM_READ:     mcycle_len = idx ? RLME_T_IDX_READ : RLME_T_PTR_READ;
			PH_MEM_WRITE:    mcycle_len = RLME_T_WRITE;
			default:         mcycle_len = RLME_T_FETCH;
		endcase
	endfunction

	// Only 00-07 and 10-17 belong to this group
	function automatic logic is_rot_left(input logic [7:0] op);
		is_rot_left = (op[7:5] == 3'h0) && (op[3] == 1'b0);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	assign tick   = (s_reg.div_cnt == 8'(TSTATE_DIV - 1));
	assign last_t = (s_reg.tcnt == mcycle_len(s_reg.phase, s_reg.indexed) - 3'h1); // RULE4

	// One rotator shared by register and memory forms
	always_comb begin
		if (s_reg.phase == PH_MEM_READ) begin
			rot_in   = mem_rdata;
			rot_thru = s_reg.opcode[RLME_THRU_BIT]; // RULE11
		end else begin
			rot_in   = s_reg.gpr[mem_rdata[2:0]]; // RULE14
			rot_thru = mem_rdata[RLME_THRU_BIT];
		end
	end

	rlme_rotate_unit u_rot (
		.operand    (rot_in),
		.thru_carry (rot_thru),
		.flags_in   (s_reg.flags),
		.result     (rot_result),
		.flags_out  (rot_flags)
	);

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		s_next      = s_reg;
		s_next.done = 1'b0;
		s_next.div_cnt = tick ? 8'h00 : s_reg.div_cnt + 8'h01;
		if (tick) begin
			s_next.tcnt = last_t ? 3'h0 : s_reg.tcnt + 3'h1;
			if (last_t) begin
				case (s_reg.phase)
					PH_FETCH_FIRST: begin
						s_next.pc = s_reg.pc + 16'h0001;
						if (mem_rdata == RLME_PFX_FIRST || mem_rdata == RLME_PFX_SECOND) begin
							s_next.indexed = 1'b1; // RULE5
							s_next.second  = (mem_rdata == RLME_PFX_SECOND); // RULE6
							s_next.phase   = PH_FETCH_SECOND;
						end else if (mem_rdata == RLME_PFX_BITOP) begin
							s_next.indexed = 1'b0;
							s_next.phase   = PH_FETCH_SECOND;
						end else begin
							// Other groups pass as a four-state no-op
							s_next.done = 1'b1;
						end
					end
					PH_FETCH_SECOND: begin
						s_next.pc = s_reg.pc + 16'h0001;
						if (s_reg.indexed) begin
							if (mem_rdata == RLME_PFX_BITOP) begin
								s_next.phase = PH_READ_DISP; // RULE5
							end else begin
								s_next.phase = PH_FETCH_FIRST;
								s_next.done  = 1'b1;
							end
						end else begin
							s_next.opcode = mem_rdata;
							s_next.phase  = PH_FETCH_FIRST;
							if (is_rot_left(mem_rdata) && mem_rdata[2:0] == RLME_SEL_MEM) begin
								s_next.ea    = {s_reg.gpr[RLME_IDX_H], s_reg.gpr[RLME_IDX_L]}; // RULE12
								s_next.phase = PH_MEM_READ;
							end else begin
								if (is_rot_left(mem_rdata)) begin
									s_next.gpr[mem_rdata[2:0]] = rot_result; // RULE14
									s_next.flags               = rot_flags;
								end
								s_next.done = 1'b1;
							end
						end
					end
					PH_READ_DISP: begin
						s_next.disp  = mem_rdata; // RULE7
						s_next.pc    = s_reg.pc + 16'h0001;
						s_next.phase = PH_FETCH_XOP;
					end
					PH_FETCH_XOP: begin
						s_next.opcode = mem_rdata; // RULE7
						s_next.pc     = s_reg.pc + 16'h0001;
						// Address add hides in the long fifth state
						s_next.ea = (s_reg.second ? s_reg.iy : s_reg.ix) // RULE2 RULE3
							+ {{8{s_reg.disp[7]}}, s_reg.disp};
						if (mem_rdata == RLME_OP_RLC_MEM || mem_rdata == RLME_OP_RL_MEM) begin
							s_next.phase = PH_MEM_READ; // RULE7 RULE11
						end else begin
							s_next.phase = PH_FETCH_FIRST;
							s_next.done  = 1'b1;
						end
					end
					PH_MEM_READ: begin
						s_next.bus.wdata = rot_result; // RULE15
						s_next.flags     = rot_flags;
						s_next.phase     = PH_MEM_WRITE;
					end
					PH_MEM_WRITE: begin
						s_next.phase = PH_FETCH_FIRST; // RULE15
						s_next.done  = 1'b1;
					end
					default: begin
						s_next.phase = PH_FETCH_FIRST;
					end
				endcase
			end
		end
		// Same address for read and write-back
		if (s_next.phase == PH_MEM_READ || s_next.phase == PH_MEM_WRITE) begin
			s_next.bus.addr = s_next.ea; // RULE15
		end else begin
			s_next.bus.addr = s_next.pc;
		end
		s_next.bus.rd = (s_next.phase != PH_MEM_WRITE);
		s_next.bus.wr = (s_next.phase == PH_MEM_WRITE);
		// Preset aborts any instruction in flight
		if (preset.load) begin
			s_next.phase                = PH_FETCH_FIRST;
			s_next.tcnt                 = 3'h0;
			s_next.div_cnt              = 8'h00;
			s_next.pc                   = preset.pc;
			s_next.ix                   = preset.index_reg_first;
			s_next.iy                   = preset.index_reg_second;
			s_next.gpr[RLME_IDX_H]      = preset.pointer_pair[15:8];
			s_next.gpr[RLME_IDX_L]      = preset.pointer_pair[7:0];
			s_next.gpr[RLME_IDX_A]      = preset.acc;
			s_next.flags                = preset.flags;
			s_next.bus.addr             = preset.pc;
			s_next.bus.rd               = 1'b1;
			s_next.bus.wr               = 1'b0;
			s_next.done                 = 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			s_reg          <= '0;
			s_reg.phase    <= PH_FETCH_FIRST;
			s_reg.pc       <= RLME_PC_RESET;
			s_reg.bus.addr <= RLME_PC_RESET;
			s_reg.bus.rd   <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign mem_bus             = s_reg.bus;
	assign status.done         = s_reg.done;
	assign status.busy         = (s_reg.phase != PH_FETCH_FIRST);
	assign status.acc          = s_reg.gpr[RLME_IDX_A];
	assign status.flags        = s_reg.flags;
	assign status.pointer_pair = {s_reg.gpr[RLME_IDX_H], s_reg.gpr[RLME_IDX_L]};
	assign status.pc           = s_reg.pc;
endmodule

/* sim/rlme_exec_assertions.sv */
/* Checker for the rotate unit's memory bus, flags and timing.
   Assumes a bind onto rlme_exec run with one sys_clk per clock state. */
`timescale 1ns/1ps
module rlme_exec_assertions #(
	parameter int TSTATE_DIV = 1
) (
	input wire logic                   sys_clk,
	input wire logic                   reset,
	input wire rlme_pkg::rlme_preset_t preset,
	input wire logic [7:0]             mem_rdata,
	input wire rlme_pkg::rlme_bus_t    mem_bus,
	input wire rlme_pkg::rlme_status_t status
);
	import rlme_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////////////
	sequence wr_start;
		$rose(mem_bus.wr);
	endsequence
	sequence write_phase;
		mem_bus.wr [*3] ##1 (!mem_bus.wr && status.done);
	endsequence
	a_rot_bits: assert property (
		wr_start |-> mem_bus.wdata[7:1] == $past(mem_rdata[6:0])
		&& status.flags[RLME_FLAG_C] == $past(mem_rdata[7])) else $error("rotate bits wrong");
	a_same_addr: assert property (
		wr_start |-> mem_bus.addr == $past(mem_bus.addr) && $past(mem_bus.rd))
		else $error("write address differs from read");
	a_sign_flag: assert property (
		wr_start |-> status.flags[RLME_FLAG_S] == mem_bus.wdata[7]) else $error("sign flag");
	a_zero_flag: assert property (
		wr_start |-> status.flags[RLME_FLAG_Z] == (mem_bus.wdata == 8'h00)) else $error("zero flag");
	a_parity_flag: assert property (
		wr_start |-> status.flags[RLME_FLAG_PV] == ~^mem_bus.wdata) else $error("parity flag");
	a_hn_clear: assert property (
		status.done && $past(mem_bus.wr) |-> !status.flags[RLME_FLAG_H]
		&& !status.flags[RLME_FLAG_N]) else $error("half carry or subtract set");
	a_write_len: assert property (
		wr_start |-> write_phase) else $error("write cycle length");
	a_read_len: assert property (
		wr_start |-> $past(mem_bus.addr, 4) == mem_bus.addr
		&& $past(mem_bus.addr, 5) != mem_bus.addr) else $error("read cycle length");
	a_done_pulse: assert property (
		status.done |=> !status.done) else $error("done longer than one cycle");
endmodule

/* sim/rlme_mem_model.sv */
/* Byte-wide memory on the far side of the rotate unit.
   Assumes combinational reads and writes on each rising edge of a write cycle. */
`timescale 1ns/1ps
module rlme_mem_model (
	input wire logic                sys_clk,
	input wire rlme_pkg::rlme_bus_t mem_bus,
	output logic [7:0]              mem_rdata
);
	import rlme_pkg::*;
	logic [7:0] mem [0:65535];
	logic [7:0] last_reg;
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'h00;
		end
		last_reg = 8'h00;
	end
	// Idle bus flips every cycle so a stale byte is never mistaken for data
	assign mem_rdata = mem_bus.rd ? mem[mem_bus.addr] : ~last_reg;
	always @(posedge sys_clk) begin
		last_reg <= mem_rdata;
		if (mem_bus.wr) begin
			mem[mem_bus.addr] <= mem_bus.wdata;
		end
	end
endmodule

/* sim/rlme_exec_tb_top.sv */
/* Self-checking bench for the left-rotate unit.
   Assumes the memory model and checker are compiled before this file. */
`timescale 1ns/1ps
module rlme_exec_tb_top;
	import rlme_pkg::*;
	logic         sys_clk = 1'b0;
	logic         reset = 1'b1;
	rlme_preset_t preset = '0;
	logic [7:0]   mem_rdata;
	rlme_bus_t    mem_bus;
	rlme_status_t status;
	int           err_count = 0;
	int           checks = 0;
	int           cycles = 0;
	always #2.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles >= 3000) begin
			err_count++;
			tally_and_finish();
		end
	end
	rlme_exec #(.TSTATE_DIV(1)) rlme_exec_i (.sys_clk(sys_clk), .reset(reset), .preset(preset),
		.mem_rdata(mem_rdata), .mem_bus(mem_bus), .status(status));
	rlme_mem_model rlme_mem_model_i (.sys_clk(sys_clk), .mem_bus(mem_bus), .mem_rdata(mem_rdata));
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Kind 0 memory operand, 1 accumulator, 2 high pointer byte
	task automatic do_op(input logic [31:0] code, input int n, input logic [15:0] ixv,
		input logic [15:0] iyv, input logic [15:0] hlv, input logic [15:0] ea,
		input logic [7:0] v, input logic thru, input logic [7:0] flg, input int kind,
		input int len);
		logic [7:0] res;
		logic [7:0] fexp;
		int         k;
		res = {v[6:0], thru ? flg[0] : v[7]};
		fexp = {res[7], res == 8'h00, flg[5], 1'b0, flg[3], ~^res, 1'b0, v[7]};
		@(negedge sys_clk);
		for (int i = 0; i < n; i++) begin
			rlme_mem_model_i.mem[16'h0100 + i] = code[31 - 8 * i -: 8];
		end
		if (kind == 0) begin
			rlme_mem_model_i.mem[ea] = v;
		end
		preset = '{1'b1, 16'h0100, (kind == 2) ? {v, 8'h00} : hlv, ixv, iyv,
			(kind == 1) ? v : 8'h00, flg};
		@(negedge sys_clk);
		preset.load = 1'b0;
		k = 0;
		do begin
			@(posedge sys_clk);
			#1;
			k++;
		end while (status.done !== 1'b1 && k < 40);
		check(16'(k), 16'(len));
		check(16'(status.flags), 16'(fexp));
		case (kind)
			0: check(16'(rlme_mem_model_i.mem[ea]), 16'(res));
			1: check(16'(status.acc), 16'(res));
			default: check(status.pointer_pair, {res, 8'h00});
		endcase
		// Next fetch must follow the last instruction byte
		check(status.pc, 16'h0100 + 16'(n));
		check(mem_bus.addr, 16'h0100 + 16'(n));
		check(16'({mem_bus.rd, mem_bus.wr, status.busy}), 16'h0004);
	endtask
	// Reset in mid-instruction must abort it and restart fetch at the reset address
	task automatic mid_reset;
		@(negedge sys_clk);
		preset = '{1'b1, 16'h0100, 16'h0000, 16'h1000, 16'h0000, 8'h00, 8'hff};
		@(negedge sys_clk);
		preset.load = 1'b0;
		repeat (3) @(negedge sys_clk);
		reset = 1'b1;
		@(negedge sys_clk);
		reset = 1'b0;
		check(status.pc, RLME_PC_RESET);
		check(16'(status.flags), 16'h0000);
		check(mem_bus.addr, RLME_PC_RESET);
		check(16'({mem_bus.rd, mem_bus.wr, status.busy, status.done}), 16'h0008);
		repeat (3) @(posedge sys_clk);
		#1;
		check(16'(status.done), 16'h0000);
		@(posedge sys_clk);
		#1;
		check(16'(status.done), 16'h0001);
		check(status.pc, RLME_PC_RESET + 16'h0001);
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic ix_rlc;
		do_op(32'hddcb0206, 4, 16'h1000, 16'h0, 16'h0, 16'h1002, 8'h88, 1'b0, 8'h00, 0, 23);
	endtask
	// Negative displacement catches a zero-extended offset
	task automatic iy_neg;
		do_op(32'hfdcbfe06, 4, 16'h0, 16'h2000, 16'h0, 16'h1ffe, 8'h80, 1'b0, 8'h28, 0, 23);
	endtask
	task automatic ix_rl_zero;
		do_op(32'hddcb7f16, 4, 16'h3000, 16'h0, 16'h0, 16'h307f, 8'h80, 1'b1, 8'h00, 0, 23);
	endtask
	task automatic ptr_rl;
		do_op(32'hcb160000, 2, 16'h0, 16'h0, 16'h2828, 16'h2828, 8'h55, 1'b1, 8'h13, 0, 15);
	endtask
	task automatic ptr_rlc;
		do_op(32'hcb060000, 2, 16'h0, 16'h0, 16'h4000, 16'h4000, 8'h7f, 1'b0, 8'h01, 0, 15);
	endtask
	task automatic reg_forms;
		do_op(32'hcb070000, 2, 16'h0, 16'h0, 16'h0, 16'h0, 8'h81, 1'b0, 8'h00, 1, 8);
		do_op(32'hcb170000, 2, 16'h0, 16'h0, 16'h0, 16'h0, 8'hff, 1'b1, 8'h01, 1, 8);
		do_op(32'hcb040000, 2, 16'h0, 16'h0, 16'h0, 16'h0, 8'h80, 1'b0, 8'h00, 2, 8);
	endtask
	task automatic tally_and_finish;
		if (err_count == 0 && checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(negedge sys_clk);
		reset = 1'b0;
		ix_rlc();
		iy_neg();
		ix_rl_zero();
		ptr_rl();
		ptr_rlc();
		reg_forms();
		mid_reset();
		tally_and_finish();
	end
endmodule
////////////////////////////////////////////////////////////////////////
bind rlme_exec rlme_exec_assertions #(.TSTATE_DIV(TSTATE_DIV)) rlme_exec_assertions_i (
	.sys_clk(sys_clk), .reset(reset), .preset(preset), .mem_rdata(mem_rdata),
	.mem_bus(mem_bus), .status(status));
